// *** dcs_pkg.sv ***
/*
  constants for the two-channel status, fault log and converter result register bank.
  assumes the register pointer is one byte wide and the serial link is the only register path.
*/
package dcs_pkg;

  // register offsets
  localparam logic [7:0] ADDR_ALERT_ONE   = 8'hD1;
  localparam logic [7:0] ADDR_STATUS_ONE  = 8'hD2;
  localparam logic [7:0] ADDR_FAULT_ONE   = 8'hD3;
  localparam logic [7:0] ADDR_ALERT_TWO   = 8'hD5;
  localparam logic [7:0] ADDR_STATUS_TWO  = 8'hD6;
  localparam logic [7:0] ADDR_FAULT_TWO   = 8'hD7;
  localparam logic [7:0] ADDR_RESULT_BASE = 8'hD8;
  localparam logic [7:0] ADDR_RESULT_LAST = 8'hE3;
  localparam logic [7:0] ADDR_CONV_CTRL   = 8'hE4;

  // status and fault field positions
  localparam int BIT_FET_ON   = 7;
  localparam int BIT_GPIO     = 6;
  localparam int BIT_SHORT    = 5;
  localparam int BIT_ENABLE   = 4;
  localparam int BIT_PWR_BAD  = 3;
  localparam int BIT_OVERCUR  = 2;
  localparam int BIT_UNDERV   = 1;
  localparam int BIT_OVERV    = 0;

  // writable masks: reserved bits stay zero
  localparam logic [7:0] FAULT_MASK = 8'h3F;
  localparam logic [7:0] ALERT_MASK = 8'h3F;
  localparam logic [7:0] CTRL_MASK  = 8'h1F;

  // converter control fields
  localparam int BIT_HALT      = 0;
  localparam int BIT_SEL_LO    = 1;
  localparam int BIT_CONV_ALRT = 4;
  localparam int BIT_BUSY      = 5;

  // converter geometry
  localparam int RESULT_W     = 10;
  localparam int RESULT_COUNT = 6;
  localparam int CHAN_COUNT   = 2;

  // reset value and device address
  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam logic [6:0] DEV_ADDR   = 7'h44;

  typedef enum logic [2:0] {
    ST_IDLE, ST_ADDR, ST_ACK_ADDR, ST_WRITE, ST_ACK_WRITE, ST_READ, ST_ACK_READ
  } dcs_link_state_t;

endpackage

// *** dcs_serial_slave.sv ***
/*
  two-wire serial slave: address match, register pointer, auto-increment reads and writes.
  assumes scl and sda arrive from pins; sda is open-drain, pulled low while o_sda_oe is high.
*/
`timescale 1ns/1ps
module dcs_serial_slave
  import dcs_pkg::*;
(
  // clock and reset
  input  wire logic       i_clock,
  input  wire logic       i_rst_n,
  // pins
  input  wire logic       i_scl,
  input  wire logic       i_sda,
  output logic            o_sda_out,
  output logic            o_sda_oe,
  // register side
  output logic [7:0]      o_ptr,
  input  wire logic [7:0] i_rdata,
  output logic            o_wr_stb,
  output logic [7:0]      o_wr_addr,
  output logic [7:0]      o_wr_data
);

  logic [1:0]      scl_sync;
  logic [1:0]      sda_sync;
  logic            scl_prev;
  logic            sda_prev;
  dcs_link_state_t state_reg;
  logic [3:0]      cnt_reg;
  logic [7:0]      shift_reg;
  logic [7:0]      tx_reg;
  logic            rw_reg;
  logic            first_reg;
  logic            nack_reg;
  logic            scl_rise;
  logic            scl_fall;
  logic            start_seen;
  logic            stop_seen;

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers; edges are taken only from the second stage
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      scl_sync <= 2'b11;
      sda_sync <= 2'b11;
      scl_prev <= 1'b1;
      sda_prev <= 1'b1;
    end else begin
      scl_sync <= {scl_sync[0], i_scl};
      sda_sync <= {sda_sync[0], i_sda};
      scl_prev <= scl_sync[1];
      sda_prev <= sda_sync[1];
    end
  end

  assign scl_rise   = scl_sync[1] & ~scl_prev;
  assign scl_fall   = ~scl_sync[1] & scl_prev;
  assign start_seen = scl_sync[1] & scl_prev & sda_prev & ~sda_sync[1];
  assign stop_seen  = scl_sync[1] & scl_prev & ~sda_prev & sda_sync[1];
  assign o_sda_out  = 1'b0;

  ////////////////////////////////////////////////////////////////////////////
  // byte engine
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_reg <= ST_IDLE;
      cnt_reg   <= 4'h0;
      shift_reg <= RESET_BYTE;
      tx_reg    <= RESET_BYTE;
      rw_reg    <= 1'b0;
      first_reg <= 1'b0;
      nack_reg  <= 1'b0;
      o_sda_oe  <= 1'b0;
      o_ptr     <= RESET_BYTE;
      o_wr_stb  <= 1'b0;
      o_wr_addr <= RESET_BYTE;
      o_wr_data <= RESET_BYTE;
    end else begin
      o_wr_stb <= 1'b0;
      if (start_seen) begin
        state_reg <= ST_ADDR;
        cnt_reg   <= 4'h0;
        first_reg <= 1'b1;
        o_sda_oe  <= 1'b0;
      end else if (stop_seen) begin
        state_reg <= ST_IDLE;
        o_sda_oe  <= 1'b0;
      end else if (scl_rise) begin
        if (state_reg == ST_ADDR || state_reg == ST_WRITE) begin
          shift_reg <= {shift_reg[6:0], sda_sync[1]};
          cnt_reg   <= cnt_reg + 4'h1;
        end else if (state_reg == ST_ACK_READ) begin
          nack_reg <= sda_sync[1];
        end
      end else if (scl_fall) begin
        case (state_reg)
          ST_ADDR: begin
            if (cnt_reg == 4'h8) begin
              if (shift_reg[7:1] == DEV_ADDR) begin
                rw_reg    <= shift_reg[0];
                o_sda_oe  <= 1'b1;
                state_reg <= ST_ACK_ADDR;
              end else begin
                state_reg <= ST_IDLE;
              end
            end
          end
          ST_ACK_ADDR, ST_ACK_READ: begin
            if (state_reg == ST_ACK_READ && nack_reg) begin
              o_sda_oe  <= 1'b0;
              state_reg <= ST_IDLE;
            end else if (state_reg == ST_ACK_READ || rw_reg) begin
              // load the byte at the pointer and drive its first bit
              tx_reg    <= i_rdata;
              o_sda_oe  <= ~i_rdata[7];
              o_ptr     <= o_ptr + 8'h01;
              cnt_reg   <= 4'h1;
              state_reg <= ST_READ;
            end else begin
              o_sda_oe  <= 1'b0;
              cnt_reg   <= 4'h0;
              state_reg <= ST_WRITE;
            end
          end
          ST_WRITE: begin
            if (cnt_reg == 4'h8) begin
              o_sda_oe  <= 1'b1;
              state_reg <= ST_ACK_WRITE;
              if (first_reg) begin
                o_ptr     <= shift_reg;
                first_reg <= 1'b0;
              end else begin
                o_wr_stb  <= 1'b1;
                o_wr_addr <= o_ptr;
                o_wr_data <= shift_reg;
                o_ptr     <= o_ptr + 8'h01;
              end
            end
          end
          ST_ACK_WRITE: begin
            o_sda_oe  <= 1'b0;
            cnt_reg   <= 4'h0;
            state_reg <= ST_WRITE;
          end
          ST_READ: begin
            if (cnt_reg == 4'h8) begin
              o_sda_oe  <= 1'b0;
              state_reg <= ST_ACK_READ;
            end else begin
              o_sda_oe <= ~tx_reg[3'(7 - cnt_reg)];
              cnt_reg  <= cnt_reg + 4'h1;
            end
          end
          default: begin
            o_sda_oe <= 1'b0;
          end
        endcase
      end
    end
  end

endmodule // dcs_serial_slave

// *** dcs_regs.sv ***
/*
  two-channel live status, sticky fault log, alert enables and converter result registers.
  assumes monitor inputs come from pins or analog comparators (synchronised here) and
  converter results arrive on the same clock as i_clock.
*/
`timescale 1ns/1ps

// Overview of operation
// - status bit 7 shows pass transistor on.
// - status bit 6 shows general purpose pin level.
// - status bit 5 shows live transistor short condition.
// - status bit 4 is one while the active-low enable pin is low.
// - status bit 3 is one while output feedback is low.
// - status bit 2 is one while overcurrent exists.
// - status bit 1 is one while undervoltage sense is low.
// - status bit 0 is one while overvoltage sense is high.
// - fault bit 5 sets on sense voltage above threshold with transistor off.
// - fault bit 4 sets when the enable pin changes state.
// - fault bit 3 sets when output feedback falls.
// - fault bit 2 sets on an overcurrent fault.
// - fault bit 1 sets when undervoltage sense falls.
// - fault bit 0 sets when overvoltage sense rises.
// - result high byte holds result bits 9 to 2.
// - result low byte holds bits 1 and 0 in bits 7 and 6.
// - halt stops free running conversion and allows single measurements.
// - alert enables choose which logged faults drive the alert output.
module dcs_regs
  import dcs_pkg::*;
(
  // clock and reset
  input  wire logic                  i_clock,
  input  wire logic                  i_rst_n,
  // serial pins
  input  wire logic                  i_scl,
  input  wire logic                  i_sda,
  output logic                       o_sda_out,
  output logic                       o_sda_oe,
  // per-channel monitor inputs, asynchronous
  input  wire logic [CHAN_COUNT-1:0] i_fet_on,
  input  wire logic [CHAN_COUNT-1:0] i_general_io_pin,
  input  wire logic [CHAN_COUNT-1:0] i_fet_short,
  input  wire logic [CHAN_COUNT-1:0] i_enable_pin_n,
  input  wire logic [CHAN_COUNT-1:0] i_output_feedback_pin,
  input  wire logic [CHAN_COUNT-1:0] i_overcurrent,
  input  wire logic [CHAN_COUNT-1:0] i_low_input_sense_pin,
  input  wire logic [CHAN_COUNT-1:0] i_high_input_sense_pin,
  // converter
  input  wire logic                  i_conv_valid,
  input  wire logic [2:0]            i_conv_sel,
  input  wire logic [RESULT_W-1:0]   i_conv_data,
  output logic                       o_conv_halt,
  output logic                       o_conv_single,
  output logic [2:0]                 o_conv_sel,
  // alert
  output logic                       o_alert_n
);

  localparam int MON_W = 8;

  logic [MON_W-1:0]    mon_async [CHAN_COUNT];
  logic [MON_W-1:0]    mon_meta  [CHAN_COUNT];
  logic [MON_W-1:0]    mon_sync  [CHAN_COUNT];
  logic [MON_W-1:0]    mon_prev  [CHAN_COUNT];
  logic [7:0]          status    [CHAN_COUNT];
  logic [7:0]          fault_set [CHAN_COUNT];
  logic [7:0]          fault_reg [CHAN_COUNT];
  logic [7:0]          alert_reg [CHAN_COUNT];
  logic [RESULT_W-1:0] result_reg [RESULT_COUNT];
  logic [7:0]          ctrl_reg;
  logic                busy_reg;
  logic                single_req_reg;
  logic [2:0]          arm_reg;
  logic                done_reg;
  logic [7:0]          ptr;
  logic [7:0]          rdata;
  logic                wr_stb;
  logic [7:0]          wr_addr;
  logic [7:0]          wr_data;
  logic                halt;

  assign halt = ctrl_reg[BIT_HALT];

  // result slot and range check for a result address
  function automatic logic [2:0] result_slot(input logic [7:0] addr);
    logic [7:0] off;
    off = addr - ADDR_RESULT_BASE;
    return off[3:1];
  endfunction

  function automatic logic is_result(input logic [7:0] addr);
    return (addr >= ADDR_RESULT_BASE) && (addr <= ADDR_RESULT_LAST);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // serial register access
  dcs_serial_slave u_slave (
    .i_clock   (i_clock),
    .i_rst_n   (i_rst_n),
    .i_scl     (i_scl),
    .i_sda     (i_sda),
    .o_sda_out (o_sda_out),
    .o_sda_oe  (o_sda_oe),
    .o_ptr     (ptr),
    .i_rdata   (rdata),
    .o_wr_stb  (wr_stb),
    .o_wr_addr (wr_addr),
    .o_wr_data (wr_data)
  );

  ////////////////////////////////////////////////////////////////////////////
  // edge detectors stay blind until sync and previous stages hold real pin levels;
  // otherwise an idle-high pin would log a false edge right after reset
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      arm_reg <= 3'h0;
    end else begin
      arm_reg <= {arm_reg[1:0], 1'b1};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // per-channel monitors: two-stage sync, then live status and fault events
  genvar ch;
  generate
    for (ch = 0; ch < CHAN_COUNT; ch++) begin : g_chan
      assign mon_async[ch] = {i_fet_on[ch], i_general_io_pin[ch], i_fet_short[ch], i_enable_pin_n[ch],
                              i_output_feedback_pin[ch], i_overcurrent[ch], i_low_input_sense_pin[ch],
                              i_high_input_sense_pin[ch]};

      always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
          mon_meta[ch] <= RESET_BYTE;
          mon_sync[ch] <= RESET_BYTE;
          mon_prev[ch] <= RESET_BYTE;
        end else begin
          mon_meta[ch] <= mon_async[ch];
          mon_sync[ch] <= mon_meta[ch];
          mon_prev[ch] <= mon_sync[ch];
        end
      end

      always_comb begin
        status[ch]              = RESET_BYTE;
        status[ch][BIT_FET_ON]  = mon_sync[ch][7];
        status[ch][BIT_GPIO]    = mon_sync[ch][6];
        status[ch][BIT_SHORT]   = mon_sync[ch][5];
        status[ch][BIT_ENABLE]  = ~mon_sync[ch][4];
        status[ch][BIT_PWR_BAD] = ~mon_sync[ch][3];
        status[ch][BIT_OVERCUR] = mon_sync[ch][2];
        status[ch][BIT_UNDERV]  = ~mon_sync[ch][1];
        status[ch][BIT_OVERV]   = mon_sync[ch][0];
      end

      // short flag is already qualified by the sense comparator; the fault also needs the transistor off
      always_comb begin
        fault_set[ch]              = RESET_BYTE;
        if (arm_reg[2]) begin
          fault_set[ch][BIT_SHORT]   = mon_sync[ch][5] & ~mon_sync[ch][7];
          fault_set[ch][BIT_ENABLE]  = mon_sync[ch][4] ^ mon_prev[ch][4];
          fault_set[ch][BIT_PWR_BAD] = ~mon_sync[ch][3] & mon_prev[ch][3];
          fault_set[ch][BIT_OVERCUR] = mon_sync[ch][2];
          fault_set[ch][BIT_UNDERV]  = ~mon_sync[ch][1] & mon_prev[ch][1];
          fault_set[ch][BIT_OVERV]   = mon_sync[ch][0] & ~mon_prev[ch][0];
        end
      end

      // a new event in the clearing cycle wins over the clear
      always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
          fault_reg[ch] <= RESET_BYTE;
        end else if (wr_stb && wr_addr == ((ch == 0) ? ADDR_FAULT_ONE : ADDR_FAULT_TWO)) begin
          fault_reg[ch] <= (wr_data & FAULT_MASK) | fault_set[ch];
        end else begin
          fault_reg[ch] <= fault_reg[ch] | fault_set[ch];
        end
      end

      always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
          alert_reg[ch] <= RESET_BYTE;
        end else if (wr_stb && wr_addr == ((ch == 0) ? ADDR_ALERT_ONE : ADDR_ALERT_TWO)) begin
          alert_reg[ch] <= wr_data & ALERT_MASK;
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // converter control and single measurement request
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ctrl_reg       <= RESET_BYTE;
      single_req_reg <= 1'b0;
    end else begin
      single_req_reg <= 1'b0;
      if (wr_stb && wr_addr == ADDR_CONV_CTRL) begin
        ctrl_reg <= wr_data & CTRL_MASK;
        // writing the channel address with halt set asks for one measurement
        if (wr_data[BIT_HALT]) begin
          single_req_reg <= 1'b1;
        end
      end
    end
  end

  // the single request leaves with the registered halt, never ahead of it
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_conv_halt   <= 1'b0;
      o_conv_single <= 1'b0;
      o_conv_sel    <= 3'h0;
    end else begin
      o_conv_halt   <= halt;
      o_conv_single <= single_req_reg;
      o_conv_sel    <= ctrl_reg[BIT_SEL_LO +: 3];
    end
  end

  // busy: always in free run, or while a single measurement is pending
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      busy_reg <= 1'b0;
      done_reg <= 1'b0;
    end else begin
      if (o_conv_single) begin
        busy_reg <= 1'b1;
      end else if (i_conv_valid) begin
        busy_reg <= 1'b0;
      end
      if (halt && busy_reg && i_conv_valid) begin
        done_reg <= 1'b1;
      end else if (wr_stb && wr_addr == ADDR_CONV_CTRL) begin
        done_reg <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // result storage; free-run results are dropped while halted so host writes stick
  generate
    for (ch = 0; ch < RESULT_COUNT; ch++) begin : g_result
      always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
          result_reg[ch] <= '0;
        end else if (wr_stb && halt && is_result(wr_addr) && result_slot(wr_addr) == 3'(ch)) begin
          // writes without halt are ignored
          if (!wr_addr[0]) begin
            result_reg[ch][RESULT_W-1:2] <= wr_data;
          end else begin
            result_reg[ch][1:0] <= wr_data[7:6];
          end
        end else if (i_conv_valid && i_conv_sel == 3'(ch) && (!halt || busy_reg)) begin
          result_reg[ch] <= i_conv_data;
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // read decode; unmapped pointers read zero
  always_comb begin
    rdata = RESET_BYTE;
    if (ptr == ADDR_ALERT_ONE) begin
      rdata = alert_reg[0];
    end else if (ptr == ADDR_STATUS_ONE) begin
      rdata = status[0];
    end else if (ptr == ADDR_FAULT_ONE) begin
      rdata = fault_reg[0];
    end else if (ptr == ADDR_ALERT_TWO) begin
      rdata = alert_reg[1];
    end else if (ptr == ADDR_STATUS_TWO) begin
      rdata = status[1];
    end else if (ptr == ADDR_FAULT_TWO) begin
      rdata = fault_reg[1];
    end else if (is_result(ptr)) begin
      if (!ptr[0]) begin
        rdata = result_reg[result_slot(ptr)][RESULT_W-1:2];
      end else begin
        rdata = {result_reg[result_slot(ptr)][1:0], 6'h00};
      end
    end else if (ptr == ADDR_CONV_CTRL) begin
      rdata = ctrl_reg;
      rdata[BIT_BUSY] = ~halt | busy_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // alert pin: low while any enabled logged fault or finished measurement stands
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_alert_n <= 1'b1;
    end else begin
      o_alert_n <= ~(|(fault_reg[0] & alert_reg[0]) | |(fault_reg[1] & alert_reg[1])
                     | (done_reg & ctrl_reg[BIT_CONV_ALRT]));
    end
  end

endmodule // dcs_regs

// *** dcs_checker.sv ***
/*
  port checker for dcs_regs.
  assumes the host holds scl low for well over four clocks per low phase.
*/
`timescale 1ns/1ps
module dcs_checker (
  // clock and reset
  input wire logic       i_clock,
  input wire logic       i_rst_n,
  // watched pins
  input wire logic       i_scl,
  input wire logic       o_sda_out,
  input wire logic       o_sda_oe,
  input wire logic       o_conv_halt,
  input wire logic       o_conv_single,
  input wire logic [2:0] o_conv_sel,
  input wire logic       o_alert_n
);
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_rst_n);
  //////////////////////////////////////////////////
  // register writes land during the ack phase, so their effects never meet a high scl
  a_data_value_low: assert property (o_sda_out == 1'b0)
    else $error("sda data value high");
  a_ack_scl_low: assert property ($rose(o_sda_oe) |-> !i_scl)
    else $error("sda pulled with scl high");
  a_reset_quiet: assert property ($rose(i_rst_n) |-> o_alert_n && !o_conv_halt && !o_sda_oe)
    else $error("outputs not idle after reset");
  a_halt_by_write: assert property ($changed(o_conv_halt) |-> !i_scl)
    else $error("halt changed with scl high");
  a_sel_by_write: assert property ($changed(o_conv_sel) |-> !i_scl)
    else $error("select changed with scl high");
  a_halt_gives_single: assert property ($rose(o_conv_halt) |-> ##[0:2] o_conv_single)
    else $error("no single request on halt");
  a_single_when_halted: assert property (o_conv_single |-> o_conv_halt ##1 !o_conv_single)
    else $error("single request not a halted pulse");
  a_alert_by_write: assert property ($rose(o_alert_n) |-> !i_scl)
    else $error("alert released with scl high");
endmodule // dcs_checker

// *** dcs_host_model.sv ***
/*
  serial host model: start, stop, bytes and acks on the two-wire link.
  assumes sda is open-drain with a pull-up resolved outside this module.
*/
`timescale 1ns/1ps
module dcs_host_model (
  // clock
  input  wire logic i_clock,
  // bus wires
  input  wire logic i_sda,
  output logic      o_scl,
  output logic      o_sda_oe
);
  // six clocks a phase keeps every scl phase above the four-clock minimum
  localparam int PHASE = 6;
  initial begin
    o_scl = 1'b1;
    o_sda_oe = 1'b0;
  end
  //////////////////////////////////////////////////
  task automatic step(input logic c, input logic d);
    o_scl <= c;
    o_sda_oe <= d;
    repeat (PHASE) @(posedge i_clock);
  endtask
  // scl falls before sda moves, so only start and stop change sda with scl high
  task automatic start();
    step(1'b0, o_sda_oe);
    step(1'b0, 1'b0);
    step(1'b1, 1'b0);
    step(1'b1, 1'b1);
  endtask
  task automatic stop();
    step(1'b0, o_sda_oe);
    step(1'b0, 1'b1);
    step(1'b1, 1'b1);
    step(1'b1, 1'b0);
  endtask
  // a 1 releases sda so the device can answer on it
  task automatic cycle(input logic b, output logic s);
    step(1'b0, o_sda_oe);
    step(1'b0, !b);
    step(1'b1, !b);
    s = i_sda;
  endtask
  task automatic send(input logic [7:0] d, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      cycle(d[i], s);
    end
    cycle(1'b1, s);
    ack = !s;
  endtask
  task automatic recv(input logic last, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      cycle(1'b1, s);
      d[i] = s;
    end
    cycle(last, s);
  endtask
endmodule // dcs_host_model

// *** dcs_regs_bench.sv ***
/*
  self-checking bench for dcs_regs: host model on the pins, bench on monitors and converter.
  assumes a pull-up on sda; the checker is bound at the foot of this file.
*/
`timescale 1ns/1ps
module dcs_regs_bench
  import dcs_pkg::*;
;
  logic                i_clock, i_rst_n, i_scl, i_sda, host_oe, o_sda_out, o_sda_oe;
  logic [1:0]          i_fet_on, i_general_io_pin, i_fet_short, i_enable_pin_n, i_overcurrent;
  logic [1:0]          i_output_feedback_pin, i_low_input_sense_pin, i_high_input_sense_pin;
  logic                i_conv_valid, o_conv_halt, o_conv_single, o_alert_n;
  logic [2:0]          i_conv_sel, o_conv_sel;
  logic [RESULT_W-1:0] i_conv_data;
  int                  bad_count = 0;
  int                  num_checks = 0;
  int                  cycles = 0;
  int                  singles = 0;
  assign i_sda = !(host_oe || (o_sda_oe && !o_sda_out));
  dcs_regs i_dcs_regs (.i_clock, .i_rst_n, .i_scl, .i_sda, .o_sda_out, .o_sda_oe, .i_fet_on,
    .i_general_io_pin, .i_fet_short, .i_enable_pin_n, .i_output_feedback_pin, .i_overcurrent,
    .i_low_input_sense_pin, .i_high_input_sense_pin, .i_conv_valid, .i_conv_sel, .i_conv_data,
    .o_conv_halt, .o_conv_single, .o_conv_sel, .o_alert_n);
  dcs_host_model i_dcs_host_model (.i_clock, .i_sda, .o_scl(i_scl), .o_sda_oe(host_oe));
  initial begin
    i_clock = 1'b0;
    forever #20 i_clock = !i_clock;
  end
  always @(posedge i_clock) begin
    cycles <= cycles + 1;
    if (o_conv_single === 1'b1) begin
      singles <= singles + 1;
    end
    if (cycles == 60000) begin
      bad_count++;
      conclude();
    end
  end
  //////////////////////////////////////////////////
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    num_checks++;
    if (g !== e) begin
      bad_count++;
      $display("FAIL %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic k0, k1, k2;
    i_dcs_host_model.start();
    i_dcs_host_model.send({DEV_ADDR, 1'b0}, k0);
    i_dcs_host_model.send(a, k1);
    i_dcs_host_model.send(d, k2);
    i_dcs_host_model.stop();
    chk("write ack", 8'h07, {5'h00, k0, k1, k2});
  endtask
  // reads select the pointer first, then turn the bus round with a repeated start
  task automatic rc(input string n, input logic [7:0] a, input logic [7:0] e);
    logic k0, k1, k2;
    logic [7:0] d;
    i_dcs_host_model.start();
    i_dcs_host_model.send({DEV_ADDR, 1'b0}, k0);
    i_dcs_host_model.send(a, k1);
    i_dcs_host_model.start();
    i_dcs_host_model.send({DEV_ADDR, 1'b1}, k2);
    i_dcs_host_model.recv(1'b1, d);
    i_dcs_host_model.stop();
    chk("read ack", 8'h07, {5'h00, k0, k1, k2});
    chk(n, e, d);
  endtask
  // c holds the asserted condition of each status bit, mapped to pin polarity here
  task automatic apply(input int ch, input logic [7:0] c);
    @(posedge i_clock);
    i_fet_on[ch] <= c[7];
    i_general_io_pin[ch] <= c[6];
    i_fet_short[ch] <= c[5];
    i_enable_pin_n[ch] <= !c[4];
    i_output_feedback_pin[ch] <= !c[3];
    i_overcurrent[ch] <= c[2];
    i_low_input_sense_pin[ch] <= !c[1];
    i_high_input_sense_pin[ch] <= c[0];
  endtask
  task automatic pulse(input int k, input logic [9:0] v);
    @(posedge i_clock);
    i_conv_valid <= 1'b1;
    i_conv_sel <= 3'(k);
    i_conv_data <= v;
    @(posedge i_clock);
    i_conv_valid <= 1'b0;
  endtask
  //////////////////////////////////////////////////
  task automatic t_status();
    logic [7:0] w;
    rc("fault after reset", ADDR_FAULT_ONE, 8'h00);
    for (int b = 0; b < 8; b++) begin
      w = 8'h01 << b;
      apply(0, w);
      apply(1, ~w);
      rc("status one", ADDR_STATUS_ONE, w);
      rc("status two", ADDR_STATUS_TWO, ~w);
    end
  endtask
  task automatic t_fault();
    apply(0, 8'h00);
    apply(1, 8'hAB);
    wr(ADDR_FAULT_ONE, 8'h00);
    wr(ADDR_FAULT_TWO, 8'h00);
    rc("fault two held", ADDR_FAULT_TWO, 8'h00);
    apply(0, 8'h3F);
    apply(0, 8'h00);
    apply(1, 8'h00);
    rc("fault one", ADDR_FAULT_ONE, 8'h3F);
    rc("fault two", ADDR_FAULT_TWO, 8'h00);
    wr(ADDR_FAULT_ONE, 8'hC0);
    rc("fault one clear", ADDR_FAULT_ONE, 8'h00);
    apply(0, 8'h10);
    wr(ADDR_FAULT_ONE, 8'h00);
    apply(0, 8'h00);
    rc("enable release", ADDR_FAULT_ONE, 8'h10);
  endtask
  task automatic t_alert();
    chk("alert idle", 8'h01, {7'h00, o_alert_n});
    wr(ADDR_ALERT_ONE, 8'h10);
    chk("alert on", 8'h00, {7'h00, o_alert_n});
    wr(ADDR_ALERT_ONE, 8'h2F);
    chk("alert masked", 8'h01, {7'h00, o_alert_n});
    wr(ADDR_ALERT_ONE, 8'h10);
    wr(ADDR_FAULT_ONE, 8'h00);
    chk("alert cleared", 8'h01, {7'h00, o_alert_n});
  endtask
  task automatic t_result();
    logic [9:0] v;
    int s;
    for (int k = 0; k < RESULT_COUNT; k++) begin
      v = 10'h2C7 + 10'(k * 83);
      pulse(k, v);
      rc("result high", ADDR_RESULT_BASE + 8'(2 * k), v[9:2]);
      rc("result low", ADDR_RESULT_BASE + 8'(2 * k + 1), {v[1:0], 6'h00});
    end
    wr(ADDR_CONV_CTRL, 8'h00);
    rc("busy free run", ADDR_CONV_CTRL, 8'h20);
    wr(ADDR_RESULT_LAST, 8'hFF);
    rc("write unhalted", ADDR_RESULT_LAST, {v[1:0], 6'h00});
    s = singles;
    wr(ADDR_CONV_CTRL, 8'h0B);
    chk("single issued", 8'(s + 1), 8'(singles));
    chk("halt and sel", 8'h0B, {4'h0, o_conv_sel, o_conv_halt});
    // halt is already set, so the result byte may be written
    wr(ADDR_RESULT_LAST, 8'hFF);
    rc("write halted", ADDR_RESULT_LAST, 8'hC0);
    pulse(5, 10'h155);
    pulse(5, 10'h3FF);
    rc("single high", ADDR_RESULT_LAST - 8'h01, 8'h55);
    rc("single low", ADDR_RESULT_LAST, 8'h40);
    rc("halt idle", ADDR_CONV_CTRL, 8'h0B);
    wr(ADDR_CONV_CTRL, 8'h00);
  endtask
  task automatic t_refuse();
    logic k;
    i_dcs_host_model.start();
    i_dcs_host_model.send(8'h8A, k);
    i_dcs_host_model.stop();
    chk("foreign address", 8'h00, {7'h00, k});
    rc("unmapped", 8'h10, 8'h00);
  endtask
  task automatic conclude();
    if (bad_count == 0 && num_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  initial begin
    i_rst_n = 1'b0;
    i_conv_valid = 1'b0;
    i_conv_sel = 3'h0;
    i_conv_data = 10'h000;
    {i_fet_on, i_general_io_pin, i_fet_short, i_overcurrent, i_high_input_sense_pin} = 10'h000;
    {i_enable_pin_n, i_output_feedback_pin, i_low_input_sense_pin} = 6'h3F;
    repeat (12) @(posedge i_clock);
    i_rst_n <= 1'b1;
    t_status();
    t_fault();
    t_alert();
    t_result();
    t_refuse();
    conclude();
  end
endmodule // dcs_regs_bench

bind dcs_regs dcs_checker i_dcs_checker (.i_clock, .i_rst_n, .i_scl, .o_sda_out, .o_sda_oe,
  .o_conv_halt, .o_conv_single, .o_conv_sel, .o_alert_n);
